// >>> verilog/alm_pkg.sv
// package: constants and types of the alarm supervision block
package alm_pkg;
  localparam int unsigned ALM_CLK_HZ = 100_000_000;
  localparam int unsigned ALM_FAST_HZ = 4;
  localparam int unsigned ALM_SLOW_HZ = 1;
  // half periods of the blink and toggle patterns, in clock cycles
  localparam int unsigned ALM_FAST_HALF = ALM_CLK_HZ / (2 * ALM_FAST_HZ);
  localparam int unsigned ALM_SLOW_HALF = ALM_CLK_HZ / (2 * ALM_SLOW_HZ);
  localparam int unsigned ALM_LOG_DEPTH = 200;
  localparam int unsigned ALM_CODE_W = 10;
  localparam int unsigned ALM_TS_W = 32;
  localparam int unsigned ALM_LEVEL_W = 4;
  localparam logic [3:0] ALM_LEVEL_FULL = 4'h_f;
  localparam logic [3:0] ALM_LEVEL_TEMP = 4'h_0;
  localparam logic [3:0] ALM_FIRST_WARN_GROUP = 4'h_8;
  // avalon register byte offsets
  localparam logic [7:0] ALM_OFS_STATUS = 8'h_00;
  localparam logic [7:0] ALM_OFS_CTRL = 8'h_04;
  localparam logic [7:0] ALM_OFS_TIME = 8'h_08;
  localparam logic [7:0] ALM_OFS_LOG_IDX = 8'h_0c;
  localparam logic [7:0] ALM_OFS_LOG_CODE = 8'h_10;
  localparam logic [7:0] ALM_OFS_LOG_TIME = 8'h_14;
  localparam logic [7:0] ALM_OFS_LOG_COUNT = 8'h_18;
  localparam int unsigned ALM_CTRL_INVERT_BIT = 0;
  localparam int unsigned ALM_STAT_TIME_SET_BIT = 8;
  localparam logic [31:0] ALM_BAD_ADDR_DATA = 32'h_0000_0000;

  typedef enum logic [1:0]
  {
    ALM_LAMP_OFF = 2'b00,
    ALM_LAMP_FAST = 2'b01,
    ALM_LAMP_SLOW = 2'b10,
    ALM_LAMP_STEADY = 2'b11
  } alm_class_t;

  typedef struct packed
  {
    logic ts_valid;
    logic [ALM_TS_W-1:0] stamp;
    logic [ALM_CODE_W-1:0] code;
  } alm_entry_t;

  typedef struct packed
  {
    logic alarm_flag;
    logic warning_flag;
    logic [ALM_CODE_W-1:0] code;
  } alm_bus_status_t;
endpackage

// >>> verilog/alm_supervisor.sv
// alarm supervision: lamp, relay, fieldbus flags, analog level, event log
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
// Behaviour
// - keep last 200 events, readable on diagnostics
// - stamp each event with calendar time
// - unset clock logs events, stamps invalid
// - calendar set and read only via diagnostics
// - calibration needed: lamp blinks 4 Hz
// - configuration failed: lamp blinks 1 Hz
// - blocking fault: lamp lit steadily
// - relay off blinking, on with start/fault
// - inverted relay configuration flips all states
// - any error sets alarm; warnings set warning
// - error code in word three bits 0..9
// - fault replaces temperature with error level
// - group n gives level n, 8..13 warnings
// - warning toggles level and full scale 1 Hz
// - start stops toggle, level held steady
// - only reset bit or power clears error
// - clear happens when reset bit falls
// - start escalates warning to fault
module alm_supervisor
  import alm_pkg::*;
#(
  parameter int unsigned FAST_HALF = ALM_FAST_HALF,
  parameter int unsigned SLOW_HALF = ALM_SLOW_HALF,
  parameter int unsigned LOG_DEPTH = ALM_LOG_DEPTH
)
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // error events from the controller's detectors (same clock)
  input wire logic error_valid_in,
  input wire logic [ALM_CODE_W-1:0] error_code_in,
  input wire logic [ALM_LEVEL_W-1:0] error_group_in,
  input wire alm_class_t error_class_in,
  input wire logic zero_calibration_done_in,
  // fieldbus output bits from the master
  input wire logic seal_start_bit_in,
  input wire logic error_reset_bit_in,
  // calendar seconds counter from the clock block
  input wire logic [ALM_TS_W-1:0] calendar_in,
  // avalon-mm slave (diagnostic port)
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic alarm_lamp_out,
  output logic fault_relay_out,
  output alm_bus_status_t bus_status_out,
  output logic [ALM_LEVEL_W-1:0] analog_level_out
);
  localparam int unsigned IDX_W = $clog2(LOG_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // synchronise the fieldbus bits, they come from another domain
  logic start_s1_r, start_s2_r, reset_s1_r, reset_s2_r, reset_d_r;
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      start_s1_r <= 1'b0;
      start_s2_r <= 1'b0;
    end
    else
    begin
      start_s1_r <= seal_start_bit_in;
      start_s2_r <= start_s1_r;
    end
  end

  // third stage only to find the falling edge of the reset bit
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      reset_s1_r <= 1'b0;
      reset_s2_r <= 1'b0;
      reset_d_r <= 1'b0;
    end
    else
    begin
      reset_s1_r <= error_reset_bit_in;
      reset_s2_r <= reset_s1_r;
      reset_d_r <= reset_s2_r;
    end
  end
  // clear only on the falling edge of the reset bit
  logic reset_fall;
  assign reset_fall = reset_d_r & ~reset_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // latched error
  logic err_active_r;
  logic [ALM_CODE_W-1:0] err_code_r;
  logic [ALM_LEVEL_W-1:0] err_group_r;
  alm_class_t err_class_r;
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      err_active_r <= 1'b0;
      err_code_r <= '0;
      err_group_r <= '0;
      err_class_r <= ALM_LAMP_OFF;
    end
    else if (error_valid_in)
    begin
      // a new error wins over a clear in the same cycle
      err_active_r <= 1'b1;
      err_code_r <= error_code_in;
      err_group_r <= error_group_in;
      err_class_r <= error_class_in;
    end
    else if (reset_fall)
    begin
      err_active_r <= 1'b0;
      err_class_r <= ALM_LAMP_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // blink dividers
  logic [$clog2(FAST_HALF)-1:0] fast_cnt_r;
  logic [$clog2(SLOW_HALF)-1:0] slow_cnt_r;
  logic fast_ph_r, slow_ph_r;
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      fast_cnt_r <= '0;
      fast_ph_r <= 1'b0;
    end
    else if (fast_cnt_r == ($clog2(FAST_HALF))'(FAST_HALF - 1))
    begin
      fast_cnt_r <= '0;
      fast_ph_r <= ~fast_ph_r;
    end
    else
      fast_cnt_r <= fast_cnt_r + 1'b1;
  end
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      slow_cnt_r <= '0;
      slow_ph_r <= 1'b0;
    end
    else if (slow_cnt_r == ($clog2(SLOW_HALF))'(SLOW_HALF - 1))
    begin
      slow_cnt_r <= '0;
      slow_ph_r <= ~slow_ph_r;
    end
    else
      slow_cnt_r <= slow_cnt_r + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // indications
  logic ctrl_invert_r;
  logic warn_state;
  logic escalated;
  // a warning under start drives lamp, relay and level as a steady fault, but warn_state stays set
  assign warn_state = err_active_r & (err_class_r == ALM_LAMP_FAST || err_class_r == ALM_LAMP_SLOW);
  assign escalated = warn_state & start_s2_r;

  logic lamp_nxt, relay_nxt;
  logic [ALM_LEVEL_W-1:0] level_nxt;
  always_comb
  begin
    lamp_nxt = 1'b0;
    relay_nxt = 1'b0;
    level_nxt = ALM_LEVEL_TEMP;
    if (err_active_r)
    begin
      level_nxt = err_group_r;
      case (err_class_r)
        ALM_LAMP_FAST: lamp_nxt = escalated | fast_ph_r;
        ALM_LAMP_SLOW: lamp_nxt = escalated | slow_ph_r;
        ALM_LAMP_STEADY: lamp_nxt = 1'b1;
        default: lamp_nxt = 1'b0;
      endcase
      relay_nxt = (err_class_r == ALM_LAMP_STEADY) | escalated;
      if (warn_state && !escalated && slow_ph_r)
        level_nxt = ALM_LEVEL_FULL;
    end
  end

  // lamp and relay: the relay idles energized when inverted
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      alarm_lamp_out <= 1'b0;
      fault_relay_out <= 1'b0;
    end
    else
    begin
      alarm_lamp_out <= lamp_nxt;
      fault_relay_out <= relay_nxt ^ ctrl_invert_r;
    end
  end

  // analog actual-value level
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      analog_level_out <= ALM_LEVEL_TEMP;
    else
      analog_level_out <= level_nxt;
  end

  // fieldbus input word
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      bus_status_out <= '0;
    end
    else
    begin
      bus_status_out.alarm_flag <= err_active_r;
      bus_status_out.warning_flag <= warn_state;
      bus_status_out.code <= err_active_r ? err_code_r : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calendar: offset added to free seconds count, set only over avalon
  logic [ALM_TS_W-1:0] time_ofs_r;
  logic time_set_r;
  logic [ALM_TS_W-1:0] now;
  assign now = calendar_in + time_ofs_r;

  ////////////////////////////////////////////////////////////////////////////
  // event log, ring of flip-flops
  alm_entry_t log_mem_r [LOG_DEPTH];
  logic [IDX_W-1:0] wr_ptr_r;
  logic [IDX_W:0] log_count_r;
  logic [IDX_W-1:0] rd_idx_r;
  logic log_evt;
  logic [ALM_CODE_W-1:0] log_code;
  assign log_evt = error_valid_in | zero_calibration_done_in;
  // calibration entries use code zero, which is no valid error code
  assign log_code = error_valid_in ? error_code_in : '0;

  // one write strobe per slot; contents need no reset, the count says what is valid
  for (genvar i = 0; i < LOG_DEPTH; i++)
  begin : g_log
    always_ff @(posedge clock_in)
    begin
      if (log_evt && wr_ptr_r == IDX_W'(i))
      begin
        log_mem_r[i].code <= log_code;
        log_mem_r[i].stamp <= now;
        log_mem_r[i].ts_valid <= time_set_r;
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wr_ptr_r <= '0;
      log_count_r <= '0;
    end
    else if (log_evt)
    begin
      // wrap onto the oldest entry once full
      wr_ptr_r <= (wr_ptr_r == IDX_W'(LOG_DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      if (log_count_r != (IDX_W + 1)'(LOG_DEPTH))
        log_count_r <= log_count_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: writes zero wait, reads one wait state
  logic rd_pend_r;
  logic wr_hit;
  assign avs_waitrequest_out = avs_read_in & ~rd_pend_r;
  assign wr_hit = avs_write_in & avs_byteenable_in[0];

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_invert_r <= 1'b0;
      rd_idx_r <= '0;
    end
    else if (avs_write_in)
    begin
      case (avs_address_in)
        ALM_OFS_CTRL:
          if (wr_hit)
            ctrl_invert_r <= avs_writedata_in[ALM_CTRL_INVERT_BIT];
        ALM_OFS_LOG_IDX:
          if (wr_hit && avs_writedata_in < LOG_DEPTH)
            rd_idx_r <= avs_writedata_in[IDX_W-1:0];
        default: ;
      endcase
    end
  end

  // calendar offset: a partial write would leave a torn time, so all lanes are needed
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      time_ofs_r <= '0;
      time_set_r <= 1'b0;
    end
    else if (avs_write_in && avs_address_in == ALM_OFS_TIME && (&avs_byteenable_in))
    begin
      time_ofs_r <= avs_writedata_in - calendar_in;
      time_set_r <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rd_pend_r <= 1'b0;
      avs_readdata_out <= ALM_BAD_ADDR_DATA;
    end
    else
    begin
      rd_pend_r <= avs_read_in & ~rd_pend_r;
      if (avs_read_in && !rd_pend_r)
      begin
        case (avs_address_in)
          ALM_OFS_STATUS:
            avs_readdata_out <= {23'h_0, time_set_r, err_active_r, warn_state, 2'b00, err_group_r};
          ALM_OFS_CTRL: avs_readdata_out <= {31'h_0, ctrl_invert_r};
          ALM_OFS_TIME: avs_readdata_out <= now;
          ALM_OFS_LOG_IDX: avs_readdata_out <= 32'(rd_idx_r);
          ALM_OFS_LOG_CODE:
            avs_readdata_out <= {21'h_0, log_mem_r[rd_idx_r].ts_valid, log_mem_r[rd_idx_r].code};
          ALM_OFS_LOG_TIME: avs_readdata_out <= log_mem_r[rd_idx_r].stamp;
          ALM_OFS_LOG_COUNT: avs_readdata_out <= {wr_ptr_r, 8'h_00, 16'(log_count_r)} & 32'h_00ff_ffff;
          default: avs_readdata_out <= ALM_BAD_ADDR_DATA;
        endcase
      end
    end
  end
endmodule

// >>> tb/alm_plc_model.sv
// fieldbus master stand-in: start level and reset-bit pulse
`timescale 1ns/100ps
module alm_plc_model
(
  input wire logic clock_in,
  input wire logic start_req_in,
  input wire logic clear_req_in,
  output logic seal_start_bit_out,
  output logic error_reset_bit_out
);
  logic [2:0] pulse_r = 3'h_0;
  initial seal_start_bit_out = 1'b0;
  always @(posedge clock_in)
  begin
    seal_start_bit_out <= start_req_in;
    if (clear_req_in)
      pulse_r <= 3'h_4;
    else if (pulse_r != 3'h_0)
      pulse_r <= pulse_r - 3'h_1;
  end
  // pulsed, never held: a held bit would keep the error latched
  assign error_reset_bit_out = (pulse_r != 3'h_0);
endmodule

// >>> tb/alm_supervisor_properties.sv
// concurrent checks on the alarm supervisor ports
`timescale 1ns/100ps
module alm_props
  import alm_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic error_valid_in,
  input wire logic [ALM_CODE_W-1:0] error_code_in,
  input wire logic [ALM_LEVEL_W-1:0] error_group_in,
  input wire alm_class_t error_class_in,
  input wire logic error_reset_bit_in,
  input wire logic avs_read_in,
  input wire logic avs_waitrequest_out,
  input wire logic alarm_lamp_out,
  input wire alm_bus_status_t bus_status_out,
  input wire logic [ALM_LEVEL_W-1:0] analog_level_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////
  sequence s_any_err;
    error_valid_in && error_class_in != ALM_LAMP_OFF;
  endsequence
  sequence s_fault;
    error_valid_in && error_class_in == ALM_LAMP_STEADY;
  endsequence
  a_read_wait: assert property (avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("read wait longer than one cycle");
  a_alarm_set: assert property (s_any_err |-> ##2 bus_status_out.alarm_flag)
    else $error("alarm flag not set");
  a_code_word: assert property (s_any_err |-> ##2 bus_status_out.code == $past(error_code_in, 2))
    else $error("error code not shown");
  a_warn_set: assert property (error_valid_in && error_class_in inside {ALM_LAMP_FAST, ALM_LAMP_SLOW}
    |-> ##2 bus_status_out.warning_flag)
    else $error("warning flag not set");
  a_lamp_steady: assert property (s_fault |-> ##2 alarm_lamp_out [*8])
    else $error("lamp not steady on fault");
  a_level_group: assert property (s_fault |-> ##2 analog_level_out == $past(error_group_in, 2))
    else $error("analog level not group");
  a_error_holds: assert property ((!error_reset_bit_in) [*6] ##0 bus_status_out.alarm_flag
    |=> bus_status_out.alarm_flag)
    else $error("error cleared without reset bit");
  a_held_reset: assert property (error_reset_bit_in && bus_status_out.alarm_flag |=> bus_status_out.alarm_flag)
    else $error("error cleared while reset bit high");
  a_clear_bound: assert property ($fell(error_reset_bit_in) |-> ##[1:6] !bus_status_out.alarm_flag)
    else $error("error not cleared after reset bit fell");
endmodule

bind alm_supervisor alm_props u_props (.*);

// >>> tb/tb.sv
// self-checking bench for the alarm supervisor
`timescale 1ns/100ps
module tb;
  import alm_pkg::*;
  localparam int FH = 4;
  localparam int SH = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ev = 1'b0;
  logic zc = 1'b0;
  logic start_req = 1'b0;
  logic clr_req = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [9:0] code = 10'h_000;
  logic [3:0] grp = 4'h_0;
  alm_class_t cls = ALM_LAMP_OFF;
  logic [31:0] cal = 32'h_0000_0000;
  logic [7:0] adr = 8'h_00;
  logic [31:0] wd = 32'h_0000_0000;
  logic [31:0] rdata, d;
  logic [31:0] av_cal, ev_cal, t0;
  logic st_bit, rs_bit, wreq, lamp, relay;
  alm_bus_status_t bs;
  logic [3:0] lvl;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  alm_plc_model u_plc (.clock_in(clk), .start_req_in(start_req), .clear_req_in(clr_req),
    .seal_start_bit_out(st_bit), .error_reset_bit_out(rs_bit));
  alm_supervisor #(.FAST_HALF(FH), .SLOW_HALF(SH)) u_dut (.clock_in(clk), .sys_rst_in(rst),
    .error_valid_in(ev), .error_code_in(code), .error_group_in(grp), .error_class_in(cls),
    .zero_calibration_done_in(zc), .seal_start_bit_in(st_bit), .error_reset_bit_in(rs_bit),
    .calendar_in(cal), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'h_f), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .alarm_lamp_out(lamp), .fault_relay_out(relay), .bus_status_out(bs), .analog_level_out(lvl));
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    cal <= cal + 32'h_1;
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      $display("MISMATCH t=%0t timeout", $time);
      final_report();
    end
  end
  ////////////////////////
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string m, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // request held until the edge where waitrequest is sampled low
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] x);
    adr <= a;
    wd <= x;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    d = rdata;
    av_cal = cal;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic inj(input logic [9:0] c, input logic [3:0] g, input alm_class_t k);
    code <= c;
    grp <= g;
    cls <= k;
    ev <= 1'b1;
    @(posedge clk);
    ev_cal = cal;
    ev <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic clr();
    clr_req <= 1'b1;
    @(posedge clk);
    clr_req <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task automatic st(input logic l, input logic r, input logic [9:0] c, input logic [3:0] v);
    chk("lamp", lamp, l);
    chk("relay", relay, r);
    chk("alarm", bs.alarm_flag, |c);
    chk("code", bs.code, c);
    chk("level", lvl, v);
  endtask
  task automatic half(input logic s, output int n);
    logic l;
    n = 0;
    @(negedge clk);
    l = s ? lvl[0] : lamp;
    while ((s ? lvl[0] : lamp) === l) @(negedge clk);
    l = ~l;
    while ((s ? lvl[0] : lamp) === l)
    begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask
  ////////////////////////
  task automatic t_fault();
    inj(10'h_065, 4'h_1, ALM_LAMP_STEADY);
    st(1'b1, 1'b1, 10'h_065, 4'h_1);
    chk("warn", bs.warning_flag, 1'b0);
    av(1'b1, ALM_OFS_LOG_IDX, 32'h_0);
    av(1'b0, ALM_OFS_LOG_CODE, 32'h_0);
    chk("log", d, 32'h_0000_0065);
    clr();
    st(1'b0, 1'b0, 10'h_000, 4'h_0);
  endtask
  task automatic t_time();
    av(1'b1, ALM_OFS_TIME, 32'h_0000_1000);
    t0 = av_cal;
    av(1'b0, ALM_OFS_STATUS, 32'h_0);
    chk("time set", d[8], 1'b1);
    av(1'b0, 8'h_fc, 32'h_0);
    chk("unmapped", d, ALM_BAD_ADDR_DATA);
    inj(10'h_066, 4'h_2, ALM_LAMP_STEADY);
    av(1'b1, ALM_OFS_LOG_IDX, 32'h_1);
    av(1'b0, ALM_OFS_LOG_CODE, 32'h_0);
    chk("stamped", d, 32'h_0000_0466);
    av(1'b0, ALM_OFS_LOG_TIME, 32'h_0);
    chk("stamp", d, 32'h_0000_1000 + ev_cal - t0);
    clr();
  endtask
  task automatic t_warn();
    int n;
    inj(10'h_068, 4'h_8, ALM_LAMP_FAST);
    chk("relay", relay, 1'b0);
    chk("warn", bs.warning_flag, 1'b1);
    half(1'b0, n);
    chk("fast", n, FH);
    half(1'b1, n);
    chk("toggle", n, SH);
    start_req <= 1'b1;
    repeat (8) @(posedge clk);
    st(1'b1, 1'b1, 10'h_068, 4'h_8);
    repeat (SH) @(posedge clk);
    st(1'b1, 1'b1, 10'h_068, 4'h_8);
    start_req <= 1'b0;
    clr();
    inj(10'h_06f, 4'h_9, ALM_LAMP_SLOW);
    half(1'b0, n);
    chk("slow", n, SH);
    chk("relay", relay, 1'b0);
    clr();
  endtask
  task automatic t_inv();
    av(1'b1, ALM_OFS_CTRL, 32'h_1);
    av(1'b0, ALM_OFS_CTRL, 32'h_0);
    chk("ctrl", d, 32'h_0000_0001);
    chk("relay idle", relay, 1'b1);
    inj(10'h_391, 4'h_7, ALM_LAMP_STEADY);
    st(1'b1, 1'b0, 10'h_391, 4'h_7);
    clr();
    av(1'b1, ALM_OFS_CTRL, 32'h_0);
  endtask
  task automatic t_fill();
    repeat (210)
    begin
      zc <= 1'b1;
      @(posedge clk);
      zc <= 1'b0;
      @(posedge clk);
    end
    av(1'b0, ALM_OFS_LOG_COUNT, 32'h_0);
    chk("count", d, 32'h_0000_00c8);
    av(1'b1, ALM_OFS_LOG_IDX, 32'h_0);
    av(1'b0, ALM_OFS_LOG_CODE, 32'h_0);
    chk("overwritten", d, 32'h_0000_0400);
  endtask
  initial
  begin
    repeat (10) @(posedge clk); // indications while powered down are not judged
    rst <= 1'b0;
    @(posedge clk);
    t_fault();
    t_time();
    t_warn();
    t_inv();
    t_fill();
    final_report();
  end
endmodule
